// ===== core/clk_dist_sync_pulse_ctrl.sv
// The register offsets and the strobed register port were decided locally.
module clk_dist_sync_pulse_ctrl #(
  parameter int unsigned POR_WAIT = clk_dist_pkg::POR_WAIT_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic ce_i,
  input wire logic [9:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic external_vco_clock_in_i,
  input wire logic pfd_ref_i,
  input wire logic fb_clk_i,
  input wire logic out_clk_i,
  input wire logic sleep_pin_n_i,
  output logic [7:0] clk_out_o,
  output clk_dist_pkg::drv_t [7:0] drv_cfg_o,
  output logic dist_ref_off_o,
  output logic dist_bias_off_o,
  output logic sleep_o,
  output logic sync_out_o,
  output logic sync_a_o,
  output logic sync_a_oe_o,
  output logic sync_b_o,
  output logic sync_b_oe_o
);
  localparam logic [clk_dist_pkg::WAIT_W-1:0] POR_CNT =
    clk_dist_pkg::WAIT_W'(POR_WAIT);
  localparam logic [clk_dist_pkg::WAIT_W-1:0] HW_CNT =
    clk_dist_pkg::WAIT_W'(clk_dist_pkg::HW_WAIT_CYC);

  logic [4:0] s1_r, s2_r, s3_r;
  logic [7:0] buf_r [clk_dist_pkg::NREG];
  logic [7:0] act_r [clk_dist_pkg::NREG];
  logic [7:0] cfg0_r;
  logic rbsel_r, upd_r, srst_r;
  logic [7:0] rdata_r;
  logic [clk_dist_pkg::WAIT_W-1:0] wait_r;
  logic slp_r;
  logic [2:0] mcnt_r;
  logic mlev_r;
  clk_dist_pkg::sync_st_t sy_st_r;
  logic [16:0] hcnt_r;
  logic [clk_dist_pkg::PN_W-1:0] pn_r;
  logic raw_r, sync_r, done_r;

  // Pins from other clock domains; edges only from second and third stage
  wire [4:0] pins = {sleep_pin_n_i, out_clk_i, fb_clk_i, pfd_ref_i,
    external_vco_clock_in_i};
  wire [4:0] rise = s2_r & ~s3_r;
  wire [4:0] fall = ~s2_r & s3_r;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_r <= clk_dist_pkg::PIN_RST;
      s2_r <= clk_dist_pkg::PIN_RST;
      s3_r <= clk_dist_pkg::PIN_RST;
    end else if (ce_i) begin
      s1_r <= pins;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Address decode
  wire out_hit = addr_i[9:3] == clk_dist_pkg::A_OUT0[9:3];
  wire [3:0] idx = out_hit ? {1'b0, addr_i[2:0]} :
    addr_i == clk_dist_pkg::A_CMOS ? clk_dist_pkg::IX_CMOS :
    addr_i == clk_dist_pkg::A_SYNC ? clk_dist_pkg::IX_SYNC :
    addr_i == clk_dist_pkg::A_SLO ? clk_dist_pkg::IX_SLO :
    addr_i == clk_dist_pkg::A_SHI ? clk_dist_pkg::IX_SHI :
    addr_i == clk_dist_pkg::A_MDIV ? clk_dist_pkg::IX_MDIV :
    clk_dist_pkg::IX_PWR;
  wire buf_hit = out_hit || addr_i == clk_dist_pkg::A_CMOS ||
    (addr_i >= clk_dist_pkg::A_SYNC && addr_i <= clk_dist_pkg::A_MDIV) ||
    addr_i == clk_dist_pkg::A_PWR;
  wire buf_wr = wr_i && buf_hit;
  wire sync_wr = wr_i && addr_i == clk_dist_pkg::A_SYNC;
  wire cfg0_wr = wr_i && addr_i == clk_dist_pkg::A_CFG0;
  wire upd_wr = wr_i && addr_i == clk_dist_pkg::A_UPD &&
    wdata_i[clk_dist_pkg::B_UPD];
  wire rst_any = rst_i || por_i || srst_r;

  // Soft reset is held for two cycles after the write
  wire srst_nxt = cfg0_r[clk_dist_pkg::B_SR_A] && cfg0_r[clk_dist_pkg::B_SR_B];
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || por_i) begin
      cfg0_r <= clk_dist_pkg::ZERO_RST;
      srst_r <= 1'b0;
    end else if (ce_i) begin
      srst_r <= srst_nxt;
      if (srst_r) begin
        cfg0_r[clk_dist_pkg::B_SR_A] <= 1'b0;
        cfg0_r[clk_dist_pkg::B_SR_B] <= 1'b0;
      end else if (cfg0_wr) begin
        cfg0_r <= wdata_i;
      end
    end
  end

  // Buffered and active register banks
  always_ff @(posedge ref_clk_i) begin
    if (rst_any) begin
      for (int i = 0; i < clk_dist_pkg::NREG; i++) begin
        buf_r[i] <= clk_dist_pkg::REG_RST[i];
        act_r[i] <= clk_dist_pkg::REG_RST[i];
      end
      upd_r <= 1'b0;
      rbsel_r <= 1'b0;
    end else if (ce_i) begin
      if (upd_r) begin
        for (int i = 0; i < clk_dist_pkg::NREG; i++) begin
          act_r[i] <= buf_r[i];
        end
      end
      upd_r <= upd_wr;
      if (done_r) begin
        act_r[clk_dist_pkg::IX_SYNC][clk_dist_pkg::B_SY_EN] <= 1'b0;
        buf_r[clk_dist_pkg::IX_SYNC][clk_dist_pkg::B_SY_EN] <= 1'b0;
      end
      // Host write lands after the self-clear so a new request survives
      if (buf_wr) begin
        buf_r[idx] <= wdata_i;
      end
      if (wr_i && addr_i == clk_dist_pkg::A_RBSEL) begin
        rbsel_r <= wdata_i[clk_dist_pkg::B_RBSEL];
      end
    end
  end

  // Readback
  wire run = wait_r == '0;
  wire [7:0] stat = {5'h00, run, slp_r, sy_st_r != clk_dist_pkg::SY_IDLE};
  wire [7:0] rd_mux = buf_hit ? (rbsel_r ? act_r[idx] : buf_r[idx]) :
    addr_i == clk_dist_pkg::A_CFG0 ? cfg0_r :
    addr_i == clk_dist_pkg::A_RBSEL ? {7'h00, rbsel_r} :
    addr_i == clk_dist_pkg::A_UPD ? {7'h00, upd_r} :
    addr_i == clk_dist_pkg::A_STAT ? stat : 8'h00;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || por_i) begin
      rdata_r <= 8'h00;
    end else if (ce_i) begin
      rdata_r <= rd_i ? rd_mux : 8'h00;
    end
  end
  assign rdata_o = rdata_r;

  // Start-up delay before outputs toggle
  always_ff @(posedge ref_clk_i) begin
    if (por_i) begin
      wait_r <= POR_CNT;
    end else if (rst_i || srst_r) begin
      wait_r <= HW_CNT;
    end else if (ce_i && !run) begin
      wait_r <= wait_r - 1'b1;
    end
  end

  // Active settings
  wire [7:0] pwr = act_r[clk_dist_pkg::IX_PWR];
  wire [7:0] mreg = act_r[clk_dist_pkg::IX_MDIV];
  wire [7:0] sreg = act_r[clk_dist_pkg::IX_SYNC];
  wire [7:0] creg = act_r[clk_dist_pkg::IX_CMOS];
  wire ref_off = pwr[clk_dist_pkg::B_REF_OFF];
  wire bias_off = pwr[clk_dist_pkg::B_BIAS_OFF];
  wire dist_on = run && !slp_r && !bias_off && !ref_off;
  wire [2:0] m_val = mreg[clk_dist_pkg::B_M_HI:0];
  wire m_direct = mreg[clk_dist_pkg::B_M_BYP] || m_val <= 3'h1;
  wire [2:0] mcnt_nxt = mcnt_r + 3'h1 >= m_val ? 3'h0 : mcnt_r + 3'h1;

  always_ff @(posedge ref_clk_i) begin
    if (rst_any) begin
      slp_r <= 1'b0;
      mcnt_r <= 3'h0;
      mlev_r <= 1'b0;
    end else if (ce_i) begin
      slp_r <= !s2_r[clk_dist_pkg::PIN_SLP];
      if (!dist_on) begin
        mcnt_r <= 3'h0;
        mlev_r <= 1'b0;
      end else if (m_direct) begin
        mlev_r <= s2_r[clk_dist_pkg::PIN_EXT];
      end else if (rise[clk_dist_pkg::PIN_EXT]) begin
        mcnt_r <= mcnt_nxt;
        mlev_r <= mcnt_nxt < (m_val >> 1);
      end
    end
  end

  // Per-output drivers
  for (genvar g = 0; g < clk_dist_pkg::NOUT; g++) begin : g_drv
    wire [7:0] oreg = act_r[g];
    wire [7:0] chreg = act_r[g & 6];
    wire safe = oreg[clk_dist_pkg::B_DRV_PD] ||
      chreg[clk_dist_pkg::B_CH_PD] || slp_r;
    always_ff @(posedge ref_clk_i) begin
      if (rst_any) begin
        drv_cfg_o[g] <= '0;
        clk_out_o[g] <= 1'b0;
      end else if (ce_i) begin
        drv_cfg_o[g].differential_swing <=
          oreg[clk_dist_pkg::B_SW_HI:clk_dist_pkg::B_SW_LO];
        drv_cfg_o[g].inv <= oreg[clk_dist_pkg::B_INV];
        drv_cfg_o[g].safe_pd <= safe;
        clk_out_o[g] <= !safe && dist_on &&
          (mlev_r ^ oreg[clk_dist_pkg::B_INV]);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_any) begin
      dist_ref_off_o <= 1'b0;
      dist_bias_off_o <= 1'b0;
      sleep_o <= 1'b0;
    end else if (ce_i) begin
      dist_ref_off_o <= ref_off;
      dist_bias_off_o <= bias_off;
      sleep_o <= slp_r;
    end
  end

  // Sync pulse generator
  wire src_fb = sreg[clk_dist_pkg::B_SY_SRC];
  wire src_rise = src_fb ? rise[clk_dist_pkg::PIN_FB] : rise[clk_dist_pkg::PIN_PFD];
  wire src_fall = src_fb ? fall[clk_dist_pkg::PIN_FB] : fall[clk_dist_pkg::PIN_PFD];
  wire src_half = src_rise || src_fall;
  wire [1:0] mode = sreg[clk_dist_pkg::B_SY_MHI:clk_dist_pkg::B_SY_MLO];
  wire shot = mode == clk_dist_pkg::MODE_SHOT;
  wire [15:0] s_val = {act_r[clk_dist_pkg::IX_SHI], act_r[clk_dist_pkg::IX_SLO]};
  wire [16:0] slot = {s_val, 1'b1};
  wire go = sreg[clk_dist_pkg::B_SY_EN] && dist_on;
  wire pn_bit = pn_r[clk_dist_pkg::PN_W-1];
  wire [clk_dist_pkg::PN_W-1:0] pn_nxt = {pn_r[clk_dist_pkg::PN_W-2:0],
    pn_r[clk_dist_pkg::PN_W-1] ^ pn_r[clk_dist_pkg::PN_TAP]};
  wire slot_bit = mode == clk_dist_pkg::MODE_PER ? 1'b1 : pn_bit;

  always_ff @(posedge ref_clk_i) begin
    if (rst_any) begin
      sy_st_r <= clk_dist_pkg::SY_IDLE;
      hcnt_r <= '0;
      pn_r <= clk_dist_pkg::PN_SEED;
      raw_r <= 1'b0;
      done_r <= 1'b0;
    end else if (ce_i) begin
      done_r <= 1'b0;
      case (sy_st_r)
        clk_dist_pkg::SY_IDLE: begin
          raw_r <= 1'b0;
          pn_r <= clk_dist_pkg::PN_SEED;
          if (go) begin
            sy_st_r <= clk_dist_pkg::SY_ARM;
          end
        end
        clk_dist_pkg::SY_ARM: begin
          if (!go) begin
            sy_st_r <= clk_dist_pkg::SY_IDLE;
          end else if (src_rise && shot) begin
            raw_r <= 1'b1;
            hcnt_r <= {1'b0, s_val};
            sy_st_r <= clk_dist_pkg::SY_SHOT;
          end else if (src_rise) begin
            raw_r <= slot_bit;
            pn_r <= pn_nxt;
            hcnt_r <= slot;
            sy_st_r <= clk_dist_pkg::SY_RUN;
          end
        end
        clk_dist_pkg::SY_SHOT: begin
          if (!go) begin
            raw_r <= 1'b0;
            sy_st_r <= clk_dist_pkg::SY_IDLE;
          end else if (src_half && hcnt_r == '0) begin
            raw_r <= 1'b0;
            done_r <= 1'b1;
            sy_st_r <= clk_dist_pkg::SY_IDLE;
          end else if (src_half) begin
            hcnt_r <= hcnt_r - 1'b1;
          end
        end
        clk_dist_pkg::SY_RUN: begin
          if (!go) begin
            raw_r <= 1'b0;
            sy_st_r <= clk_dist_pkg::SY_IDLE;
          end else if (src_half && hcnt_r == '0) begin
            raw_r <= slot_bit;
            pn_r <= pn_nxt;
            hcnt_r <= slot;
          end else if (src_half) begin
            raw_r <= 1'b0;
            hcnt_r <= hcnt_r - 1'b1;
          end
        end
        default: begin
          raw_r <= 1'b0;
          sy_st_r <= clk_dist_pkg::SY_IDLE;
        end
      endcase
    end
  end

  // Retimed to output clock rising edge; pulses may land up to one output clock cycle late
  wire cm = creg[clk_dist_pkg::B_CM_EN];
  wire a_on = cm && !creg[clk_dist_pkg::B_CM_AOFF] && !slp_r;
  wire b_on = cm && !creg[clk_dist_pkg::B_CM_BOFF] && !slp_r;
  always_ff @(posedge ref_clk_i) begin
    if (rst_any) begin
      sync_r <= 1'b0;
      sync_out_o <= 1'b0;
      sync_a_o <= 1'b0;
      sync_a_oe_o <= 1'b0;
      sync_b_o <= 1'b0;
      sync_b_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (rise[clk_dist_pkg::PIN_OUT]) begin
        sync_r <= raw_r;
      end
      sync_out_o <= !cm && !slp_r && sync_r;
      sync_a_oe_o <= a_on;
      sync_b_oe_o <= b_on;
      sync_a_o <= a_on && (sync_r ^ creg[clk_dist_pkg::B_CM_AINV]);
      sync_b_o <= b_on && (sync_r ^ creg[clk_dist_pkg::B_CM_BINV]);
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i || por_i);

  wire pd_all = drv_cfg_o[0].safe_pd && drv_cfg_o[7].safe_pd;
  sequence s_commit;
    upd_r ##1 !upd_r;
  endsequence

  property p_sleep_pd;
    ce_i && slp_r && !srst_r |=> pd_all;
  endproperty
  a_sleep_pd: assert property (p_sleep_pd) else $error("sleep not safe");

  property p_ref_off;
    ce_i && ref_off && !srst_r |=> dist_ref_off_o;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("ref off lost");

  property p_bias_off;
    ce_i && bias_off && !srst_r |=> dist_bias_off_o && !clk_out_o[0];
  endproperty
  a_bias_off: assert property (p_bias_off) else $error("bias off lost");

  property p_commit;
    ce_i && upd_wr && !srst_r ##1 ce_i |-> s_commit;
  endproperty
  a_commit: assert property (p_commit) else $error("commit flag");

  property p_hold;
    ce_i && !upd_r && !srst_r && !done_r |=> $stable(act_r[clk_dist_pkg::IX_SLO]);
  endproperty
  a_hold: assert property (p_hold) else $error("active changed");

  property p_self_clear;
    ce_i && done_r && !upd_r && !srst_r |=> !sreg[clk_dist_pkg::B_SY_EN];
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("no clear");

  property p_shot_end;
    ce_i && sy_st_r == clk_dist_pkg::SY_SHOT && go && src_half && hcnt_r == '0
      && !srst_r |=> !raw_r && done_r && sy_st_r == clk_dist_pkg::SY_IDLE;
  endproperty
  a_shot_end: assert property (p_shot_end) else $error("shot width");

  property p_rest;
    ce_i && !go && !srst_r |=> !raw_r;
  endproperty
  a_rest: assert property (p_rest) else $error("sync not idle");

  property p_retime;
    $changed(sync_r) && !$past(srst_r) |-> $past(ce_i && rise[clk_dist_pkg::PIN_OUT]);
  endproperty
  a_retime: assert property (p_retime) else $error("not retimed");

  property p_cmos;
    ce_i && !a_on && !srst_r |=> !sync_a_oe_o && !sync_a_o;
  endproperty
  a_cmos: assert property (p_cmos) else $error("cmos not tristate");
endmodule

// ===== core/clk_dist_pkg.sv
package clk_dist_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int POR_WAIT_MS = 70;
  localparam int HW_WAIT_US = 2;
  localparam int POR_WAIT_CYC = CLK_HZ / 1000 * POR_WAIT_MS;
  localparam int HW_WAIT_CYC = CLK_HZ / 1_000_000 * HW_WAIT_US;
  localparam int WAIT_W = 21;

  localparam logic [9:0] A_CFG0 = 10'h000;
  localparam logic [9:0] A_RBSEL = 10'h004;
  localparam logic [9:0] A_OUT0 = 10'h0f0;
  localparam logic [9:0] A_CMOS = 10'h0f9;
  localparam logic [9:0] A_SYNC = 10'h192;
  localparam logic [9:0] A_SLO = 10'h193;
  localparam logic [9:0] A_SHI = 10'h194;
  localparam logic [9:0] A_MDIV = 10'h195;
  localparam logic [9:0] A_STAT = 10'h196;
  localparam logic [9:0] A_PWR = 10'h230;
  localparam logic [9:0] A_UPD = 10'h232;

  localparam int NREG = 14;
  localparam int NOUT = 8;
  localparam logic [3:0] IX_CMOS = 4'h8;
  localparam logic [3:0] IX_SYNC = 4'h9;
  localparam logic [3:0] IX_SLO = 4'ha;
  localparam logic [3:0] IX_SHI = 4'hb;
  localparam logic [3:0] IX_MDIV = 4'hc;
  localparam logic [3:0] IX_PWR = 4'hd;

  localparam int B_DRV_PD = 0;
  localparam int B_SW_LO = 1;
  localparam int B_SW_HI = 2;
  localparam int B_INV = 3;
  localparam int B_CH_PD = 4;
  localparam int B_CM_EN = 0;
  localparam int B_CM_AOFF = 1;
  localparam int B_CM_BOFF = 2;
  localparam int B_CM_AINV = 3;
  localparam int B_CM_BINV = 4;
  localparam int B_SY_MLO = 0;
  localparam int B_SY_MHI = 1;
  localparam int B_SY_SRC = 2;
  localparam int B_SY_EN = 4;
  localparam int B_M_HI = 2;
  localparam int B_M_BYP = 3;
  localparam int B_REF_OFF = 1;
  localparam int B_BIAS_OFF = 4;
  localparam int B_SR_A = 2;
  localparam int B_SR_B = 5;
  localparam int B_UPD = 0;
  localparam int B_RBSEL = 0;

  localparam logic [1:0] MODE_SHOT = 2'h0;
  localparam logic [1:0] MODE_PER = 2'h1;
  localparam logic [1:0] MODE_PN = 2'h2;

  localparam logic [7:0] OUT_RST = 8'h04;
  localparam logic [7:0] MDIV_RST = 8'h01;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam logic [NREG-1:0][7:0] REG_RST = {ZERO_RST, MDIV_RST, ZERO_RST,
    ZERO_RST, ZERO_RST, ZERO_RST, {NOUT{OUT_RST}}};

  localparam int PN_W = 17;
  localparam int PN_TAP = 13;
  localparam logic [PN_W-1:0] PN_SEED = 17'h1ffff;

  localparam int PIN_EXT = 0;
  localparam int PIN_PFD = 1;
  localparam int PIN_FB = 2;
  localparam int PIN_OUT = 3;
  localparam int PIN_SLP = 4;
  localparam logic [4:0] PIN_RST = 5'h10;

  typedef enum logic [1:0] {SY_IDLE, SY_ARM, SY_SHOT, SY_RUN} sync_st_t;

  typedef struct packed {
    logic [1:0] differential_swing;
    logic inv;
    logic safe_pd;
  } drv_t;
endpackage

// ===== verification/sync_conv_model.sv
module sync_conv_model (
  input wire logic sync_i,
  output logic pfd_o,
  output logic fb_o,
  output logic out_o,
  output logic ext_o,
  output int edges_o,
  output int width_o
);
  timeunit 1ns;
  timeprecision 100ps;
  time t0;
  // Free running sources, odd offsets so no edge lines up with the system clock
  initial begin
    pfd_o = 1'b0;
    #137;
    forever #400 pfd_o = ~pfd_o;
  end
  initial begin
    fb_o = 1'b0;
    #291;
    forever #600 fb_o = ~fb_o;
  end
  initial begin
    out_o = 1'b0;
    #17;
    forever #60 out_o = ~out_o;
  end
  // Uneven duty so a pass-through is visible
  initial begin
    ext_o = 1'b0;
    #13;
    forever begin
      ext_o = 1'b1;
      #150;
      ext_o = 1'b0;
      #250;
    end
  end
  // Converter side counts rising edges only
  initial begin
    edges_o = 0;
    width_o = 0;
    t0 = 0;
  end
  always @(posedge sync_i) begin
    edges_o++;
    t0 = $time;
  end
  always @(negedge sync_i) begin
    width_o = int'($time - t0);
  end
endmodule

// ===== verification/clk_dist_sync_pulse_ctrl_test.sv
module clk_dist_sync_pulse_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sleep_pin_n = 1'b1;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] clk_out;
  clk_dist_pkg::drv_t [7:0] drv;
  logic pfd, fb, oclk, ext, ref_off, bias_off, slp, sy, sa, sa_oe, sb, sb_oe;
  logic [31:0] rs = 32'h1eaa;
  logic [7:0] mv[6] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h01, 8'h0b};
  logic [7:0] cv[5] = '{8'h01, 8'h03, 8'h05, 8'h19, 8'h00};
  int ss[4] = '{0, 1, 3, 256};
  int sr[4] = '{0, 0, 1, 0};
  int num_errors = 0;
  int total_checks = 0;
  int edges, width, e, n;
  int mb[1024];
  int ma[1024];

  always #25 clk = ~clk;

  sync_conv_model far (.sync_i(sy), .pfd_o(pfd), .fb_o(fb), .out_o(oclk), .ext_o(ext),
    .edges_o(edges), .width_o(width));

  clk_dist_sync_pulse_ctrl #(.POR_WAIT(50)) dut (.ref_clk_i(clk), .rst_i(rst), .por_i(por),
    .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .external_vco_clock_in_i(ext), .pfd_ref_i(pfd), .fb_clk_i(fb), .out_clk_i(oclk),
    .sleep_pin_n_i(sleep_pin_n), .clk_out_o(clk_out), .drv_cfg_o(drv),
    .dist_ref_off_o(ref_off), .dist_bias_off_o(bias_off), .sleep_o(slp), .sync_out_o(sy),
    .sync_a_o(sa), .sync_a_oe_o(sa_oe), .sync_b_o(sb), .sync_b_oe_o(sb_oe));

  task finish_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (x !== g) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", s, x, g);
    end
  endtask

  // Async sources sampled by the design, so counts get a window
  task near(input string s, input int x, input int g, input int t);
    total_checks++;
    if (g < x - t || g > x + t) begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", s, x, g);
    end
  endtask

  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  function automatic int pn_ones(int k);
    logic [16:0] s;
    int c;
    s = '1;
    c = 0;
    for (int i = 0; i < k; i++) begin
      c += int'(s[16]);
      s = {s[15:0], s[16] ^ s[13]};
    end
    return c;
  endfunction

  task init_m();
    for (int i = 0; i < 1024; i++) mb[i] = 0;
    for (int i = 240; i < 248; i++) mb[i] = 4;
    mb[10'h195] = 1;
    ma = mb;
  endtask

  task do_reset(input logic p);
    rst <= 1'b1;
    por <= p;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    init_m();
  endtask

  task wrr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    mb[a] = d;
  endtask

  task rdc(input logic [9:0] a, input logic [7:0] x, input string s);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(s, x, rdata);
  endtask

  task commit();
    wrr(10'h232, 8'h01);
    ma = mb;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task chk_drv(input logic z);
    logic [7:0] r, c;
    for (int o = 0; o < 8; o++) begin
      r = 8'(ma[240 + o]);
      c = 8'(ma[240 + (o & 6)]);
      chk("drv", {r[2:1], r[3], r[0] | c[4] | z}, drv[o]);
    end
  endtask

  task wsy(input logic v);
    int k;
    k = 0;
    while (sy !== v && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k == 3000) begin
      chk("wait", 0, 1);
      finish_test();
    end
  endtask

  initial begin
    do_reset(1'b1);
    repeat (20) @(posedge clk);
    rdc(10'h196, 8'h00, "running");
    repeat (60) @(posedge clk);
    rdc(10'h196, 8'h04, "running");
    for (int i = 240; i < 248; i++) rdc(10'(i), 8'h04, "default");
    rdc(10'h195, 8'h01, "default");
    rdc(10'h3ff, 8'h00, "unmapped");
    for (int k = 0; k < 3; k++) begin
      for (int o = 0; o < 8; o++) begin
        rs = xs(rs);
        wrr(10'(240 + o), rs[7:0] & 8'h1f);
      end
      chk_drv(1'b0);
      commit();
      chk_drv(1'b0);
      for (int o = 0; o < 8; o++) rdc(10'(240 + o), 8'(mb[240 + o]), "outreg");
    end
    for (int o = 0; o < 8; o++) wrr(10'(240 + o), 8'h04);
    foreach (cv[i]) begin
      wrr(10'h230, {3'h0, cv[i][1], 2'h0, cv[i][2], 1'b0});
      commit();
      chk("ref_off", cv[i][2], ref_off);
      chk("bias_off", cv[i][1], bias_off);
    end
    foreach (mv[i]) begin
      wrr(10'h195, mv[i]);
      commit();
      repeat (50) @(posedge clk);
      n = 0;
      repeat (480) begin
        @(posedge clk);
        n += int'(clk_out[0]);
      end
      e = (mv[i][3] || mv[i] < 2) ? 180 : 480 * (mv[i] / 2) / mv[i];
      near("duty", e, n, 6);
    end
    foreach (ss[i]) begin
      wrr(10'h193, 8'(ss[i]));
      wrr(10'h194, 8'(ss[i] >> 8));
      wrr(10'h192, sr[i] ? 8'h14 : 8'h10);
      e = edges;
      commit();
      wsy(1'b1);
      wsy(1'b0);
      repeat (60) @(posedge clk);
      near("width", (ss[i] + 1) * (sr[i] ? 600 : 400), width, 200);
      chk("shots", e + 1, edges);
      mb[10'h192] = sr[i] ? 4 : 0;
      rdc(10'h192, 8'(mb[10'h192]), "enable");
    end
    // High divider byte cleared from the last shot's value
    wrr(10'h194, 8'h00);
    wrr(10'h193, 8'h01);
    wrr(10'h192, 8'h11);
    commit();
    repeat (100) @(posedge clk);
    e = edges;
    repeat (3200) @(posedge clk);
    near("periodic", 100, edges - e, 2);
    wrr(10'h192, 8'h01);
    commit();
    repeat (40) @(posedge clk);
    chk("rest", 0, sy);
    e = edges;
    repeat (100) @(posedge clk);
    chk("rest", e, edges);
    wrr(10'h193, 8'h00);
    wrr(10'h192, 8'h12);
    e = edges;
    commit();
    wsy(1'b1);
    repeat (3200) @(posedge clk);
    near("pn", pn_ones(200), edges - e, 4);
    wrr(10'h192, 8'h02);
    commit();
    foreach (cv[i]) begin
      wrr(10'h0f9, cv[i]);
      commit();
      chk("a_oe", cv[i][0] & ~cv[i][1], sa_oe);
      chk("b_oe", cv[i][0] & ~cv[i][2], sb_oe);
      if (cv[i][0]) chk("sync", 0, sy);
      chk("a_pol", cv[i][3] & cv[i][0] & ~cv[i][1], sa);
      chk("b_pol", cv[i][4] & cv[i][0] & ~cv[i][2], sb);
    end
    @(posedge clk);
    sleep_pin_n <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk("sleep", 1, slp);
    chk_drv(1'b1);
    chk("clk_out", 0, clk_out);
    rs = xs(rs);
    wrr(10'h0f5, rs[7:0] & 8'h0f);
    commit();
    rdc(10'h0f5, 8'(mb[10'h0f5]), "sleep_port");
    sleep_pin_n <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk_drv(1'b0);
    wrr(10'h000, 8'h81);
    wrr(10'h000, 8'ha5);
    repeat (5) @(posedge clk);
    init_m();
    mb[0] = 8'h81;
    rdc(10'h000, 8'h81, "cfg0");
    rdc(10'h0f5, 8'h04, "softrst");
    chk_drv(1'b0);
    do_reset(1'b0);
    repeat (20) @(posedge clk);
    rdc(10'h196, 8'h00, "hwrst");
    repeat (40) @(posedge clk);
    rdc(10'h196, 8'h04, "hwrst");
    chk_drv(1'b0);
    finish_test();
  end
endmodule
